// [common/ssms_pkg.sv]
// Constants, state codes and carrier types of the special-mode selector.
package ssms_pkg;
  localparam int MM_W_DEF = 16;
  localparam int AW = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [AW-1:0] REG_CONFIG = 8'h00;
  localparam logic [AW-1:0] REG_RAMP = 8'h04;
  localparam logic [AW-1:0] REG_STATUS = 8'h08;
  localparam logic [AW-1:0] REG_SELECT = 8'h0C;
  localparam logic [AW-1:0] REG_DIAG = 8'h10;
  localparam logic [AW-1:0] REG_IRQ_STAT = 8'h14;
  localparam logic [AW-1:0] REG_IRQ_MASK = 8'h18;
  localparam int CFG_HOLD_BIT = 0;
  localparam int CFG_BRAKE_BIT = 1;
  localparam int ST_EMERG_BIT = 0;
  localparam int ST_STAND_BIT = 1;
  localparam int ST_MOTION_BIT = 2;
  localparam int ST_NORMAL_BIT = 3;
  localparam int ST_HOLD_BIT = 4;
  localparam int ST_TRANS_BIT = 26;
  localparam int SEL_EMERG_BIT = 0;
  localparam int SEL_STAND_BIT = 1;
  localparam int SEL_MOTION_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int IRQ_EMERG_BIT = 0;
  localparam int IRQ_STAND_BIT = 1;
  localparam int IRQ_TRANS_BIT = 2;
  localparam logic [1:0] CFG_RST = 2'h0;
  localparam logic [15:0] RAMP_RST = 16'h0100;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [15:0] DIAG_NONE = 16'h0000;
  localparam logic [15:0] DIAG_MOTION = 16'h0300;
  localparam logic [15:0] DIAG_EMERG = 16'h0320;
  localparam logic [15:0] DIAG_ST_TORQUE = 16'h0321;
  localparam logic [15:0] DIAG_ST_HOLD = 16'h0322;
  typedef enum logic [4:0] {
    S_NORMAL = 5'h01,
    S_MOTION = 5'h02,
    S_TRANS = 5'h04,
    S_EMERG = 5'h08,
    S_STAND = 5'h10
  } ssms_state_type;
  typedef struct packed {
    logic emergency_select_input;
    logic mode_select_input;
    logic enabling_control_input;
  } ssms_sel_type;
  typedef struct packed {
    logic torque_removal;
    logic brake_control;
    logic operating_hold;
    logic ramp_then_torque_off;
    logic ramp_then_hold;
  } ssms_fn_type;
endpackage : ssms_pkg

// [src/ssms_selector.sv]
// Safety special-mode selector with emergency and standstill modes and AHB-Lite registers.
// Operation
// - Emergency selection always heads for emergency mode.
// - Emergency evaluated independently, highest priority.
// - Emergency entered only after torque-off stop ramp.
// - Emergency applies torque removal, brake if configured.
// - Emergency active shows its diagnostic code.
// - Emergency selection presence is readable.
// - Emergency-active status bit is readable.
// - During a stop ramp, previous code and functions stay.
// - In-transition status bit sits at position 26.
// - Standstill variant: torque removal or operating hold.
// - Torque-off variant adds brake when configured.
// - Standstill on mode-select alone, no higher selection.
// - Standstill stop ramp chosen by configured variant.
// - Emergency to torque-off standstill switches directly.
// - Each standstill variant has its own diagnostic code.
// - Standstill selection presence is readable.
// - Standstill-active status bit is readable.
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module ssms_selector #(
  parameter int MM_W = ssms_pkg::MM_W_DEF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ssms_pkg::ssms_sel_type sel_in,
  input wire logic [MM_W-1:0] motion_mode_select_input,
  output ssms_pkg::ssms_fn_type fn_out,
  output logic [15:0] diag_code,
  output logic in_transition,
  output logic irq
);
  import ssms_pkg::*;

  if (MM_W < 1 || MM_W > 16) begin : g_bad_width
    $error("MM_W must lie between 1 and 16.");
  end

  localparam int PW = MM_W + 3;

  function automatic ssms_state_type pick_target(input logic es, input logic ms,
                                                 input logic ec, input logic any_mm);
    if (es) begin
      pick_target = S_EMERG;
    end else if (ms && ec && any_mm) begin
      pick_target = S_MOTION;
    end else if (ms) begin
      pick_target = S_STAND;
    end else begin
      pick_target = S_NORMAL;
    end
  endfunction : pick_target

  // Pin synchroniser; a filtered bit follows once stages two and three agree.
  logic [PW-1:0] sy1_q;
  logic [PW-1:0] sy2_q;
  logic [PW-1:0] sy3_q;
  logic [PW-1:0] flt_q;
  logic [PW-1:0] agree_w;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sy1_q <= '0;
      sy2_q <= '0;
      sy3_q <= '0;
    end else begin
      sy1_q <= {sel_in, motion_mode_select_input};
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
    end
  end

  assign agree_w = ~(sy2_q ^ sy3_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flt_q <= '0;
    end else begin
      flt_q <= (flt_q & ~agree_w) | (sy2_q & agree_w);
    end
  end

  ssms_sel_type sel_w;
  logic any_mm_w;
  ssms_state_type tgt_w;

  assign sel_w = flt_q[PW-1:MM_W];
  assign any_mm_w = |flt_q[MM_W-1:0];
  assign tgt_w = pick_target(sel_w.emergency_select_input, sel_w.mode_select_input,
                             sel_w.enabling_control_input, any_mm_w);

  // Configuration registers written over the bus.
  logic [1:0] cfg_q;
  logic [15:0] ramp_q;
  logic [IRQ_W-1:0] mask_q;
  logic cfg_hold;
  logic cfg_brake;

  assign cfg_hold = cfg_q[CFG_HOLD_BIT];
  assign cfg_brake = cfg_q[CFG_BRAKE_BIT];

  // Mode sequencer.
  ssms_state_type state_q;
  ssms_state_type prev_q;
  ssms_state_type tgt_q;
  ssms_state_type last_q;
  logic ss2_q;
  logic stand_hold_q;
  logic [15:0] cnt_q;
  logic ramp_done;
  logic need_ramp;

  assign ramp_done = cnt_q >= ramp_q;
  // Emergency always ramps; standstill ramps unless leaving emergency into variant one.
  assign need_ramp = (tgt_w == S_EMERG) ||
                     (tgt_w == S_STAND && !(state_q == S_EMERG && !cfg_hold));

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_NORMAL;
      prev_q <= S_NORMAL;
      tgt_q <= S_NORMAL;
      ss2_q <= 1'b0;
      stand_hold_q <= 1'b0;
      cnt_q <= 16'h0000;
    end else begin
      if (cnt_q != 16'hFFFF) begin
        cnt_q <= cnt_q + 16'h0001;
      end
      unique case (state_q)
        S_NORMAL, S_MOTION, S_EMERG, S_STAND: begin
          if (tgt_w != state_q) begin
            if (need_ramp) begin
              state_q <= S_TRANS;
              tgt_q <= tgt_w;
              ss2_q <= (tgt_w == S_STAND) && cfg_hold;
              cnt_q <= 16'h0000;
            end else begin
              state_q <= tgt_w;
              prev_q <= tgt_w;
              stand_hold_q <= 1'b0;
            end
          end
        end
        S_TRANS: begin
          if (tgt_w != tgt_q) begin
            if (tgt_w == S_EMERG || tgt_w == S_STAND) begin
              tgt_q <= tgt_w;
              ss2_q <= (tgt_w == S_STAND) && cfg_hold;
              cnt_q <= 16'h0000;
            end else begin
              state_q <= tgt_w;
              prev_q <= tgt_w;
              stand_hold_q <= 1'b0;
            end
          end else if (ramp_done) begin
            state_q <= tgt_q;
            prev_q <= tgt_q;
            stand_hold_q <= ss2_q;
          end
        end
        default: begin
          state_q <= S_EMERG;
          prev_q <= S_EMERG;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      last_q <= S_NORMAL;
    end else begin
      last_q <= state_q;
    end
  end

  // Safety functions follow the last settled mode while a ramp runs.
  ssms_state_type eff_w;
  ssms_fn_type fn_d;
  logic [15:0] diag_d;

  assign eff_w = (state_q == S_TRANS) ? prev_q : state_q;

  always_comb begin
    fn_d.torque_removal = (eff_w == S_EMERG) ||
                          (eff_w == S_STAND && !stand_hold_q);
    fn_d.brake_control = fn_d.torque_removal && cfg_brake;
    fn_d.operating_hold = (eff_w == S_STAND) && stand_hold_q;
    fn_d.ramp_then_torque_off = (state_q == S_TRANS) && !ss2_q;
    fn_d.ramp_then_hold = (state_q == S_TRANS) && ss2_q;
  end

  always_comb begin
    unique case (eff_w)
      S_EMERG: diag_d = DIAG_EMERG;
      S_STAND: diag_d = stand_hold_q ? DIAG_ST_HOLD : DIAG_ST_TORQUE;
      S_MOTION: diag_d = DIAG_MOTION;
      default: diag_d = DIAG_NONE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fn_out <= '0;
      diag_code <= DIAG_NONE;
      in_transition <= 1'b0;
    end else begin
      fn_out <= fn_d;
      diag_code <= diag_d;
      in_transition <= (state_q == S_TRANS);
    end
  end

  // Readable status and selection words.
  logic [31:0] status_w;
  logic [31:0] select_w;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[ST_EMERG_BIT] = (state_q == S_EMERG);
    status_w[ST_STAND_BIT] = (state_q == S_STAND);
    status_w[ST_MOTION_BIT] = (state_q == S_MOTION);
    status_w[ST_NORMAL_BIT] = (state_q == S_NORMAL);
    status_w[ST_HOLD_BIT] = stand_hold_q;
    status_w[ST_TRANS_BIT] = (state_q == S_TRANS);
    select_w = 32'h0000_0000;
    select_w[SEL_EMERG_BIT] = sel_w.emergency_select_input;
    select_w[SEL_STAND_BIT] = (tgt_w == S_STAND);
    select_w[SEL_MOTION_BIT] = (tgt_w == S_MOTION);
  end

  // AHB-Lite slave: one wait state, then the data phase completes.
  logic take_w;
  logic pend_q;
  logic wr_q;
  logic [AW-1:0] addr_q;
  logic wr_en;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [31:0] rd_w;

  assign take_w = hsel && htrans[1] && hready;
  assign wr_en = pend_q && wr_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else if (take_w) begin
      pend_q <= 1'b1;
      wr_q <= hwrite;
      addr_q <= haddr[AW-1:0];
      hreadyout <= 1'b0;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      hreadyout <= 1'b1;
      if (!wr_q) begin
        hrdata <= rd_w;
      end
    end
  end

  always_comb begin
    unique case (addr_q)
      REG_CONFIG: rd_w = {30'h0, cfg_q};
      REG_RAMP: rd_w = {16'h0, ramp_q};
      REG_STATUS: rd_w = status_w;
      REG_SELECT: rd_w = select_w;
      REG_DIAG: rd_w = {16'h0, diag_code};
      REG_IRQ_STAT: rd_w = {29'h0, irq_stat_q};
      REG_IRQ_MASK: rd_w = {29'h0, mask_q};
      default: rd_w = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_q <= CFG_RST;
      ramp_q <= RAMP_RST;
      mask_q <= MASK_RST;
    end else if (wr_en) begin
      if (addr_q == REG_CONFIG) begin
        cfg_q <= hwdata[1:0];
      end
      if (addr_q == REG_RAMP) begin
        ramp_q <= hwdata[15:0];
      end
      if (addr_q == REG_IRQ_MASK) begin
        mask_q <= hwdata[IRQ_W-1:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear in the same cycle.
  logic [IRQ_W-1:0] ev_w;
  logic [IRQ_W-1:0] clr_w;

  always_comb begin
    ev_w = '0;
    ev_w[IRQ_EMERG_BIT] = (state_q == S_EMERG) && (last_q != S_EMERG);
    ev_w[IRQ_STAND_BIT] = (state_q == S_STAND) && (last_q != S_STAND);
    ev_w[IRQ_TRANS_BIT] = (state_q == S_TRANS) && (last_q != S_TRANS);
    clr_w = (wr_en && addr_q == REG_IRQ_STAT) ? hwdata[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= ev_w | (irq_stat_q & ~clr_w);
      irq <= |(irq_stat_q & mask_q);
    end
  end

  // Checks on the sequencer and its outputs.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_es_heads_emerg: assert property (
    sel_w.emergency_select_input |=>
      (state_q == S_EMERG) || (state_q == S_TRANS && tgt_q == S_EMERG))
    else $error("Emergency selection did not steer toward emergency mode.");

  chk_emerg_via_ramp: assert property (
    $rose(state_q == S_EMERG) |-> $past(state_q) == S_TRANS && $past(ramp_done))
    else $error("Emergency mode entered without a completed stop ramp.");

  chk_emerg_functions: assert property (
    state_q == S_EMERG |=> fn_out.torque_removal && fn_out.brake_control == $past(cfg_brake))
    else $error("Emergency mode functions wrong.");

  chk_emerg_diag_code: assert property (
    state_q == S_EMERG |=> diag_code == DIAG_EMERG)
    else $error("Emergency diagnostic code missing.");

  chk_ramp_diag_hold: assert property (
    state_q == S_TRANS && $past(state_q) == S_TRANS |=> $stable(diag_code))
    else $error("Diagnostic code changed during a stop ramp.");

  chk_transition_bit: assert property (
    in_transition == $past(state_q == S_TRANS))
    else $error("Transition flag disagrees with sequencer.");

  chk_stand_variant: assert property (
    state_q == S_STAND |=>
      fn_out.operating_hold == $past(stand_hold_q) &&
      fn_out.torque_removal == !$past(stand_hold_q))
    else $error("Standstill variant functions wrong.");

  chk_emerg_to_stand: assert property (
    state_q == S_EMERG && tgt_w == S_STAND && !cfg_hold |=> state_q == S_STAND)
    else $error("Emergency to torque-off standstill was not direct.");

  chk_stand_ramp_kind: assert property (
    state_q == S_NORMAL && tgt_w == S_STAND |=>
      state_q == S_TRANS && ss2_q == $past(cfg_hold))
    else $error("Standstill stop ramp kind wrong.");

  cov_emerg_reached: cover property (state_q == S_TRANS ##1 state_q == S_EMERG);
  cov_hold_reached: cover property (state_q == S_STAND && stand_hold_q);
  cov_restart: cover property (state_q == S_TRANS && tgt_q == S_STAND && tgt_w == S_EMERG);
  cov_direct_stand: cover property (state_q == S_EMERG ##1 state_q == S_STAND);

endmodule : ssms_selector

// [verification/ssms_sel_driver.sv]
// Model of the controller that drives the selection pins of the special-mode selector.
`timescale 1ns/1ps
module ssms_sel_driver #(
  parameter int MM_W = ssms_pkg::MM_W_DEF
) (
  input wire logic clk,
  input wire logic es_req,
  input wire logic ms_req,
  input wire logic ec_req,
  input wire logic mm_req,
  input wire logic [3:0] mm_idx,
  output ssms_pkg::ssms_sel_type sel_in,
  output logic [MM_W-1:0] motion_mode_select_input
);
  import ssms_pkg::*;
  always_ff @(posedge clk) begin
    sel_in.emergency_select_input <= es_req;
    sel_in.mode_select_input <= ms_req;
    sel_in.enabling_control_input <= ec_req;
  end
  // Never more than one motion mode is requested at a time.
  always_ff @(posedge clk) begin
    motion_mode_select_input <= mm_req ? (MM_W'(1) << mm_idx) : '0;
  end
endmodule : ssms_sel_driver

// [verification/tb_top.sv]
// Self-checking testbench of the special-mode selector.
`timescale 1ns/1ps
module tb_top;
  import ssms_pkg::*;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, in_transition, irq, es, ms, ec, mm;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mm_idx;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] diag_code;
  logic [MM_W_DEF-1:0] mms;
  ssms_sel_type sel;
  ssms_fn_type fn;
  int fail_count, cmp_count;
  bit saw_tr, saw_oth;
  ssms_selector i_ssms_selector (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sel_in(sel),
    .motion_mode_select_input(mms), .fn_out(fn), .diag_code(diag_code),
    .in_transition(in_transition), .irq(irq));
  ssms_sel_driver i_ssms_sel_driver (.clk(clk), .es_req(es), .ms_req(ms), .ec_req(ec),
    .mm_req(mm), .mm_idx(mm_idx), .sel_in(sel), .motion_mode_select_input(mms));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic timeout(input string name);
    fail_count++;
    $display("CHECK FAILED %s expected done seen timeout", name);
    final_report();
  endtask : timeout
  task automatic hs_wait(input string name);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) timeout(name);
    end while (hreadyout !== 1'b1);
  endtask : hs_wait
  // Holds the address phase until hready is seen high, then the data phase likewise.
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {24'h0, a};
    hs_wait("address phase");
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hs_wait("data phase");
    rd = hrdata;
  endtask : ahb
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdchk
  task automatic setsel(input logic e, input logic m, input logic c, input logic x);
    @(posedge clk);
    es <= e;
    ms <= m;
    ec <= c;
    mm <= x;
  endtask : setsel
  // Notes whether a ramp or a third code was passed on the way to the expected code.
  task automatic wait_diag(input logic [15:0] exp);
    int n;
    logic [15:0] d0;
    d0 = diag_code;
    n = 0;
    saw_tr = 0;
    saw_oth = 0;
    while (diag_code !== exp) begin
      @(posedge clk);
      if (in_transition === 1'b1) saw_tr = 1;
      if (diag_code !== d0 && diag_code !== exp) saw_oth = 1;
      n++;
      if (n > 200) timeout("diag_code");
    end
  endtask : wait_diag
  task automatic wait_tr;
    int n;
    n = 0;
    while (in_transition !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > 20) timeout("in_transition");
    end
  endtask : wait_tr
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    {es, ms, ec, mm} = 4'h0;
    mm_idx = 4'h0;
    fail_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rdchk("config reset", REG_CONFIG, 32'h0);
    chk("hresp okay", 32'h0, {31'h0, hresp});
    rdchk("ramp reset", REG_RAMP, {16'h0, RAMP_RST});
    rdchk("mask reset", REG_IRQ_MASK, 32'h0);
    rdchk("unmapped", 8'h1C, 32'h0);
    ahb(1'b1, REG_RAMP, 32'hA);
    ahb(1'b1, REG_IRQ_MASK, 32'h7);
    ahb(1'b1, REG_CONFIG, 32'h2);
    rdchk("ramp", REG_RAMP, 32'hA);
    for (int i = 0; i < 2; i++) begin
      mm_idx <= i[0] ? 4'hF : 4'h0;
      setsel(1'b0, 1'b1, 1'b1, 1'b1);
      wait_diag(DIAG_MOTION);
      rdchk("select motion", REG_SELECT, 32'h4);
      setsel(1'b0, 1'b0, 1'b0, 1'b0);
      wait_diag(DIAG_NONE);
    end
    // Emergency requested together with every other selection.
    setsel(1'b1, 1'b1, 1'b1, 1'b1);
    wait_tr();
    chk("diag in ramp", 32'h0, {16'h0, diag_code});
    chk("fn in ramp", 32'h2, {27'h0, fn});
    ahb(1'b0, REG_STATUS, 32'h0);
    chk("status trans", 32'h1, {31'h0, rd[ST_TRANS_BIT]});
    rdchk("select emerg", REG_SELECT, 32'h1);
    wait_diag(DIAG_EMERG);
    chk("fn emerg", 32'h18, {27'h0, fn});
    rdchk("status emerg", REG_STATUS, 32'h1);
    rdchk("irq stat", REG_IRQ_STAT, 32'h5);
    chk("irq raised", 32'h1, {31'h0, irq});
    ahb(1'b1, REG_IRQ_MASK, 32'h0);
    rdchk("irq stat kept", REG_IRQ_STAT, 32'h5);
    chk("irq masked", 32'h0, {31'h0, irq});
    ahb(1'b1, REG_IRQ_MASK, 32'h7);
    ahb(1'b1, REG_IRQ_STAT, 32'h5);
    rdchk("irq cleared", REG_IRQ_STAT, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
    setsel(1'b0, 1'b1, 1'b0, 1'b1);
    wait_diag(DIAG_ST_TORQUE);
    chk("direct switch", 32'h0, {31'h0, saw_tr});
    chk("fn stand torque", 32'h18, {27'h0, fn});
    rdchk("status stand", REG_STATUS, 32'h2);
    rdchk("select stand", REG_SELECT, 32'h2);
    setsel(1'b0, 1'b0, 1'b0, 1'b0);
    wait_diag(DIAG_NONE);
    ahb(1'b1, REG_CONFIG, 32'h3);
    setsel(1'b0, 1'b1, 1'b0, 1'b0);
    wait_tr();
    chk("fn hold ramp", 32'h1, {27'h0, fn});
    wait_diag(DIAG_ST_HOLD);
    chk("fn stand hold", 32'h4, {27'h0, fn});
    rdchk("status hold", REG_STATUS, 32'h12);
    setsel(1'b0, 1'b0, 1'b0, 1'b0);
    wait_diag(DIAG_NONE);
    // Emergency raised while the standstill ramp is running.
    setsel(1'b0, 1'b1, 1'b0, 1'b0);
    wait_tr();
    setsel(1'b1, 1'b1, 1'b0, 1'b0);
    wait_diag(DIAG_EMERG);
    chk("no standstill stop", 32'h0, {31'h0, saw_oth});
    // Brake control is dropped once it is no longer configured.
    ahb(1'b1, REG_CONFIG, 32'h1);
    repeat (2) @(posedge clk);
    chk("fn emerg no brake", 32'h10, {27'h0, fn});
    // Leaving emergency into the hold variant must still run a stop ramp.
    setsel(1'b0, 1'b1, 1'b0, 1'b0);
    wait_diag(DIAG_ST_HOLD);
    chk("ramp from emerg", 32'h1, {31'h0, saw_tr});
    chk("emerg code held", 32'h0, {31'h0, saw_oth});
    final_report();
  end
endmodule : tb_top
